// File: rtl/irq_vector_map.v
// Interrupt flag, enable and vector mapping block
`timescale 1ns/1ps
`default_nettype none
`include "irq_map_defines.vh"
// Behaviour
// - Condition pulse sets source flag bit
// - Enable bit written by software, held
// - Request needs flag and enable together
// - Request stays until flag cleared
// - Global enable gates all maskable requests
// - Each used vector tied to one peripheral
// - Vector 0 reset, 1 scan checker
// - Vector 2 level monitor, 3-5 ports
// - Vectors 6,7 real-time counter sources
// - Vectors 8-12 timer A sources
// - 13 timer B, 17 comparator, others empty
// - Vectors 20,21 converter sources
// - Vectors 24-26 two-wire and SPI
// - Vectors 27-29 USART, 30 EEPROM
module irq_vector_map #(
    parameter NS = `NUM_SOURCES
) (
    input wire sys_clk_in,
    input wire nrst_in,
    input wire [NS-1:0] event_in,
    input wire [NS-1:0] flag_clear_in,
    input wire enable_wr_in,
    input wire [NS-1:0] enable_data_in,
    input wire global_enable_in,
    input wire nmi_event_in,
    input wire nmi_clear_in,
    output reg [NS-1:0] irq_flag_reg_out,
    output reg [NS-1:0] irq_control_reg_out,
    output reg nmi_flag_out,
    output reg irq_valid_out,
    output reg [`VEC_WIDTH-1:0] irq_vector_out
);
    // Reset release stages
    reg rst_s1_q;
    reg rst_s2_q;
    wire rst_n;
    // Peripheral flag and enable state
    reg [NS-1:0] flag_q;
    reg [NS-1:0] flag_d;
    reg [NS-1:0] en_q;
    reg [NS-1:0] en_d;
    // Scan checker flag, kept apart from the maskable sources
    reg nmi_q;
    reg nmi_d;
    // Gated requests and their vector image
    wire [NS-1:0] src_req;
    reg [`NUM_VECTORS-1:0] vec_req;
    // Picker result, registered before it leaves the block
    wire pick_valid;
    wire [`VEC_WIDTH-1:0] pick_vec;
    reg [`VEC_WIDTH-1:0] vec_d;
    // Loop index for the per-bit flag update
    integer k;

    // Next value of a set/clear flag bit; the set side wins a tie
    // so that an event landing in the clear cycle is never lost
    function set_wins;
        input cur_bit;
        input clr_bit;
        input set_bit;
        begin
            set_wins = (cur_bit & ~clr_bit) | set_bit;
        end
    endfunction

    // Reset released through two flops so release is clean; the
    // assertion side stays asynchronous so a glitch still clears all
    always @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_s1_q <= 1'h0;
            rst_s2_q <= 1'h0;
        end else begin
            rst_s1_q <= 1'h1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rst_n = rst_s2_q;

    // Per-bit flag update, set wins over clear
    always @* begin
        flag_d = {NS{1'h0}};
        for (k = 0; k < NS; k = k + 1) begin
            flag_d[k] = set_wins(flag_q[k], flag_clear_in[k],
                event_in[k]);
        end
    end

    // The scan checker flag uses the same set-wins update
    always @* begin
        nmi_d = set_wins(nmi_q, nmi_clear_in, nmi_event_in);
    end

    // Enables change only on a software write and are held otherwise
    always @* begin
        en_d = en_q;
        if (enable_wr_in) begin
            en_d = enable_data_in;
        end
    end

    // Flag state
    always @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= {NS{1'h0}};
        end else begin
            flag_q <= flag_d;
        end
    end

    // Enable state
    always @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            en_q <= {NS{1'h0}};
        end else begin
            en_q <= en_d;
        end
    end

    // Scan checker flag state
    always @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            nmi_q <= 1'h0;
        end else begin
            nmi_q <= nmi_d;
        end
    end

    // Per-source request is a level while flag and enable hold; the
    // spare source has a flag and an enable but no vector behind it
    assign src_req = flag_q & en_q & {NS{global_enable_in}};

    // Fixed source to vector wiring; unlisted vectors stay zero
    always @* begin
        vec_req = {`NUM_VECTORS{1'h0}};
        // Reset owns vector 0 and never requests through the map
        vec_req[0] = 1'h0;
        // Scan checker, not gated by the global enable
        vec_req[1] = nmi_q;
        // Level monitor and the three pin ports
        vec_req[2] = src_req[`SRC_VLM];
        vec_req[3] = src_req[`SRC_PORTA];
        vec_req[4] = src_req[`SRC_PORTB];
        vec_req[5] = src_req[`SRC_PORTC];
        // Real-time counter: count and periodic tick
        vec_req[6] = src_req[`SRC_RTC_CNT];
        vec_req[7] = src_req[`SRC_RTC_PIT];
        // Timer A: low and high byte, then the three compare channels
        vec_req[8] = src_req[`SRC_TA_LOW];
        vec_req[9] = src_req[`SRC_TA_HIGH];
        vec_req[10] = src_req[`SRC_TA_COMPARE0];
        vec_req[11] = src_req[`SRC_TA_CMP1];
        vec_req[12] = src_req[`SRC_TA_CMP2];
        // Timer B and the analog comparator
        vec_req[13] = src_req[`SRC_TB];
        vec_req[17] = src_req[`SRC_ACMP];
        // Converter: result ready and window compare
        vec_req[20] = src_req[`SRC_ADC_RDY];
        vec_req[21] = src_req[`SRC_ADC_WIN];
        // Two-wire target, two-wire controller and SPI
        vec_req[24] = src_req[`SRC_TWI_TGT];
        vec_req[25] = src_req[`SRC_TWI_CTL];
        vec_req[26] = src_req[`SRC_SPI];
        // USART receive, buffer empty and transmit, then EEPROM
        vec_req[27] = src_req[`SRC_USART_RX];
        vec_req[28] = src_req[`SRC_USART_DRE];
        vec_req[29] = src_req[`SRC_USART_TX];
        vec_req[30] = src_req[`SRC_NVM_EE];
    end

    // Priority picker, lowest vector wins
    vector_pick #(
        .N(`NUM_VECTORS),
        .W(`VEC_WIDTH)
    ) u_vector_pick (
        .req_in(vec_req),
        .valid_out(pick_valid),
        .vec_out(pick_vec)
    );

    // Idle vector is forced to zero so the core never sees a stale one
    always @* begin
        vec_d = `VEC_NONE;
        if (pick_valid) begin
            vec_d = pick_vec;
        end
    end

    // Flag image; registering costs a cycle but keeps outputs on flops
    always @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            irq_flag_reg_out <= {NS{1'h0}};
        end else begin
            irq_flag_reg_out <= flag_q;
        end
    end

    // Enable image as last written
    always @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            irq_control_reg_out <= {NS{1'h0}};
        end else begin
            irq_control_reg_out <= en_q;
        end
    end

    // Scan checker flag image; it ignores the global enable
    always @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            nmi_flag_out <= 1'h0;
        end else begin
            nmi_flag_out <= nmi_q;
        end
    end

    // Request pending towards the core
    always @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            irq_valid_out <= 1'h0;
        end else begin
            irq_valid_out <= pick_valid;
        end
    end

    // Vector presented to the core, zero while nothing is pending
    always @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            irq_vector_out <= `VEC_NONE;
        end else begin
            irq_vector_out <= vec_d;
        end
    end
endmodule
`default_nettype wire

// File: rtl/irq_map_defines.vh
// Vector numbers, source positions and widths for the vector map
`ifndef IRQ_MAP_DEFINES_VH
`define IRQ_MAP_DEFINES_VH
`define NUM_VECTORS 31
`define VEC_WIDTH 5
`define NUM_SOURCES 23
`define VEC_RESET 5'h00
`define VEC_NMI 5'h01
`define VEC_NONE 5'h00
// Source bit positions on the flag and enable buses
`define SRC_VLM 0
`define SRC_PORTA 1
`define SRC_PORTB 2
`define SRC_PORTC 3
`define SRC_RTC_CNT 4
`define SRC_RTC_PIT 5
`define SRC_TA_LOW 6
`define SRC_TA_HIGH 7
`define SRC_TA_COMPARE0 8
`define SRC_TA_CMP1 9
`define SRC_TA_CMP2 10
`define SRC_TB 11
`define SRC_ACMP 12
`define SRC_ADC_RDY 13
`define SRC_ADC_WIN 14
`define SRC_TWI_TGT 15
`define SRC_TWI_CTL 16
`define SRC_SPI 17
`define SRC_USART_RX 18
`define SRC_USART_DRE 19
`define SRC_USART_TX 20
`define SRC_NVM_EE 21
`define SRC_SPARE 22
`endif

// File: rtl/vector_pick.v
// Lowest-numbered active vector picker
`timescale 1ns/1ps
`default_nettype none
module vector_pick #(
    parameter N = 31,
    parameter W = 5
) (
    input wire [N-1:0] req_in,
    output reg valid_out,
    output reg [W-1:0] vec_out
);
    integer i;
    // Scan downward so the lowest index is the one left standing
    always @* begin
        valid_out = 1'h0;
        vec_out = {W{1'h0}};
        for (i = N - 1; i >= 1; i = i - 1) begin
            if (req_in[i]) begin
                valid_out = 1'h1;
                vec_out = i[W-1:0];
            end
        end
    end
endmodule
`default_nettype wire

// File: bench/irq_vector_map_properties.sv
// Port checks for the interrupt vector map
`timescale 1ns/1ps
`default_nettype none
module irq_vector_map_properties #(parameter NS = 23) (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic [NS-1:0] event_in,
    input wire logic [NS-1:0] flag_clear_in,
    input wire logic enable_wr_in,
    input wire logic global_enable_in,
    input wire logic nmi_flag_out,
    input wire logic [NS-1:0] irq_flag_reg_out,
    input wire logic [NS-1:0] irq_control_reg_out,
    input wire logic irq_valid_out,
    input wire logic [4:0] irq_vector_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);
    // Maskable request present; the NMI vector is exempt from gating
    wire mask = irq_valid_out && irq_vector_out != 5'h01;
    a_flag_sets: assert property (|event_in |-> ##2
        (irq_flag_reg_out & $past(event_in, 2)) == $past(event_in, 2))
        else $error("flag not set");
    a_flag_stays: assert property (($past(irq_flag_reg_out) &
        ~irq_flag_reg_out & ~$past(flag_clear_in, 2)) == '0)
        else $error("flag dropped");
    a_enable_held: assert property ($changed(irq_control_reg_out) |->
        $past(enable_wr_in) || $past(enable_wr_in, 2))
        else $error("enable moved");
    a_req_needs: assert property (mask |->
        |(irq_flag_reg_out & irq_control_reg_out)) else $error("stray req");
    a_gate_global: assert property (mask |->
        $past(global_enable_in) || $past(global_enable_in, 2))
        else $error("ungated req");
    a_no_empty: assert property (irq_valid_out |-> !(irq_vector_out
        inside {0, 14, 15, 16, 18, 19, 22, 23})) else $error("empty vec");
    a_nmi_vector: assert property ($rose(nmi_flag_out) |-> ##[0:1]
        irq_vector_out == 5'h01) else $error("nmi vec");
    a_idle_zero: assert property (!irq_valid_out |->
        irq_vector_out == 5'h00) else $error("idle vec");
    // Spare top source bit has no vector, so it cannot raise a request
    localparam logic [NS-1:0] MAPPED = {1'h0, {(NS-1){1'h1}}};
    a_req_raised: assert property (|(irq_flag_reg_out &
        irq_control_reg_out & MAPPED) && $past(global_enable_in) |->
        irq_valid_out) else $error("req missing");
    c_top: cover property (irq_vector_out == 5'h1E);
    c_nmi: cover property (irq_vector_out == 5'h01);
    c_drop: cover property ($fell(irq_valid_out));
endmodule
`default_nettype wire

// File: bench/cpu_core_model.sv
// Stand-in CPU core taking vectored requests
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
    input wire logic clk_in,
    input wire logic gie_req_in,
    input wire logic valid_in,
    input wire logic [4:0] vec_in,
    output logic gie_out,
    output logic [4:0] taken_vec_out
);
    // Software global enable passes straight to the map
    assign gie_out = gie_req_in;
    // Core latches the vector it would service next
    always @(posedge clk_in) if (valid_in) taken_vec_out <= vec_in;
endmodule
`default_nettype wire

// File: bench/irq_vector_map_tb.sv
// Self-checking bench for the interrupt vector map
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
module irq_vector_map_tb;
    logic clk = 0, nrst = 0, ewr = 0, gie = 0, gie_o, nev = 0, ncl = 0;
    logic nf, vld;
    logic [22:0] ev = 0, cl = 0, en = 0, fl, ctl;
    logic [4:0] vec, taken;
    int num_errors = 0, checked = 0, cyc = 0;
    // Vector per source bit; bit 22 is a spare with no vector
    byte vt [23] = '{2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 17, 20, 21,
        24, 25, 26, 27, 28, 29, 30, 0};
    irq_vector_map u_irq_vector_map (.sys_clk_in(clk), .nrst_in(nrst),
        .event_in(ev), .flag_clear_in(cl), .enable_wr_in(ewr),
        .enable_data_in(en), .global_enable_in(gie_o), .nmi_event_in(nev),
        .nmi_clear_in(ncl), .irq_flag_reg_out(fl), .irq_control_reg_out(ctl),
        .nmi_flag_out(nf), .irq_valid_out(vld), .irq_vector_out(vec));
    cpu_core_model u_cpu_core_model (.clk_in(clk), .gie_req_in(gie),
        .valid_in(vld), .vec_in(vec), .gie_out(gie_o), .taken_vec_out(taken));
    task step(int n); repeat (n) @(posedge clk); #1; endtask
    // One-cycle pulses, then wait out the two-edge answer
    task drive(logic [22:0] e, c, logic s = 0, x = 0);
        ev = e; cl = c; nev = s; ncl = x; step(1);
        ev = 0; cl = 0; nev = 0; ncl = 0; step(2);
    endtask
    task wr_en(logic [22:0] m);
        en = m; ewr = 1; step(1); ewr = 0; step(2);
        `CHK("enables", m, ctl)
    endtask
    task t_map;
        gie = 1; wr_en('1);
        for (int i = 0; i < 23; i++) begin
            drive(23'h1 << i, 0);
            `CHK("flag", 23'h1 << i, fl)
            `CHK("vector", 5'(vt[i]), vec)
            `CHK("valid", i < 22, vld)
            drive(0, 23'h1 << i);
            `CHK("drop", 1'b0, vld)
        end
    endtask
    task t_gate;
        gie = 0; drive(23'h8, 0);
        `CHK("gated", 1'b0, vld)
        gie = 1; step(2);
        `CHK("ungated", 5'h05, vec)
        wr_en(0);
        `CHK("disabled", 1'b0, vld)
        drive(0, '1); wr_en('1);
        drive(23'h2, 23'h2);
        `CHK("set wins", 23'h2, fl)
        `CHK("port a", 5'h03, vec)
        drive(0, 23'h2);
        `CHK("cleared", 23'h0, fl)
    endtask
    task t_prio;
        drive(23'h200020, 0); step(4);
        `CHK("lowest", 5'h07, vec)
        `CHK("taken", 5'h07, taken)
        drive(0, 23'h20);
        `CHK("next", 5'h1E, vec)
        drive(0, '1); gie = 0;
        drive(0, 0, 1, 0);
        `CHK("nmi", 5'h01, vec)
        `CHK("nmi flag", 1'h1, nf)
        drive(0, 0, 0, 1);
        `CHK("nmi off", 1'b0, nf)
    endtask
    task conclude;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) if (++cyc > 3000) begin num_errors++; conclude; end
    initial begin
        step(4); nrst = 1; step(3);
        `CHK("idle", 5'h00, vec)
        t_map; t_gate; t_prio; conclude;
    end
endmodule
bind irq_vector_map irq_vector_map_properties #(.NS(NS)) u_props (.*);
`default_nettype wire
